// ---- rtl/wrtc_top.sv ----
// Operation
// - Three run modes, shared by all shapes
// - Continuous mode replays waveform back to back
// - Reset gives continuous run, self-armed enable
// - Remote abort stops armed continuous output at once
// - Common feed copies run mode across channels
// - Self-armed ignores enable, abort; runs when on
// - Armed idles, starts on enable, stops on abort
// - Armed enable from bus, event or front
// - Event input edge: rising, falling or either
// - Triggered mode plays one burst of count cycles per trigger
// - Hold first-sample level between triggered cycles
// - Front source ignores remote trigger commands
// - Bus source ignores hardware trigger inputs
// - Remote abort may end running triggered cycle
// - Lockout retrigger drops triggers while playing
// - Override retrigger restarts cycle at any time outside holdoff
// - Only the selected trigger source is active
// - Trigger edge: rising, falling or both
// - Zero delay disables delayed trigger
// - Burst of one to one million cycles
// - Optional minimum pulse width qualifier
// - Optional maximum width; both form window
// - Delay in sample clocks, zero to 8M
// - Gated mode finishes cycle after gate closes
`timescale 1ns/10ps
`default_nettype none
`include "wrtc_defines.svh"
module wrtc_top (
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Stimulus pins
    input  wire logic        front_connector_source,
    input  wire logic        event_in,
    input  wire logic        panel_push_stimulus,
    // Playback engine
    input  wire logic        output_on,
    input  wire logic        func_valid,
    input  wire logic        wave_done,
    output logic             wave_start,
    output logic             play_active,
    output logic             hold_first,
    output logic             armed_idle,
    output logic [1:0]       ch1_run_mode
);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic edge_hit(input logic cur, input logic prv, input logic [1:0] sel);
        edge_hit = (sel[0] & cur & ~prv) | (sel[1] & ~cur & prv);
    endfunction

    function automatic logic [22:0] clamp_delay(input logic [31:0] v);
        clamp_delay = (v > {9'h000, `WRTC_MAX_DELAY}) ? `WRTC_MAX_DELAY : v[22:0];
    endfunction

    function automatic logic [19:0] clamp_count(input logic [31:0] v);
        if (v == 32'h0000_0000) begin
            clamp_count = `WRTC_RST_COUNT;
        end else if (v > {12'h000, `WRTC_MAX_COUNT}) begin
            clamp_count = `WRTC_MAX_COUNT;
        end else begin
            clamp_count = v[19:0];
        end
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    logic [`WRTC_CTRL_W-1:0] ctrl_r;
    logic [1:0]              ch1_mode_r;
    logic [22:0]             delay_r;
    logic [19:0]             count_r;
    logic [23:0]             minw_r;
    logic [23:0]             maxw_r;
    logic [23:0]             holdoff_r;
    logic [23:0]             timer_r;
    logic                    cmd_trig_r;
    logic                    cmd_en_r;
    logic                    cmd_abort_r;
    wrtc_pkg::wrtc_state_t   state_r;
    wrtc_pkg::wrtc_state_t   state_nxt;
    logic [22:0]             delay_cnt_r;
    logic [19:0]             burst_r;
    logic [23:0]             hold_cnt_r;
    logic [23:0]             width_r;
    logic [23:0]             tmr_cnt_r;
    logic [2:0]              sync1_r;
    logic [2:0]              sync2_r;
    logic [2:0]              prev_r;

    logic [1:0] run_mode;
    logic       armed;
    logic [1:0] en_src;
    logic [1:0] trg_src;
    logic       override;
    logic [1:0] trg_edge;
    logic [1:0] evt_edge;
    logic       wr_en;
    logic       rd_en;

    assign run_mode = ctrl_r[`WRTC_F_RUN +: 2];
    assign armed    = ctrl_r[`WRTC_F_ENMODE];
    assign en_src   = ctrl_r[`WRTC_F_ENSRC +: 2];
    assign trg_src  = ctrl_r[`WRTC_F_TRGSRC +: 2];
    assign override = ctrl_r[`WRTC_F_RETRIG];
    assign trg_edge = ctrl_r[`WRTC_F_TRGEDGE +: 2];
    assign evt_edge = ctrl_r[`WRTC_F_EVTEDGE +: 2];
    assign wr_en    = psel & penable & pwrite;
    assign rd_en    = psel & ~penable & ~pwrite;
    assign pready   = 1'b1;
    assign ch1_run_mode = ch1_mode_r;

    // ****************************************
    // Register writes
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r     <= `WRTC_RST_CTRL;
            ch1_mode_r <= 2'h0;
            delay_r    <= 23'h00_0000;
            count_r    <= `WRTC_RST_COUNT;
            minw_r     <= 24'h00_0000;
            maxw_r     <= 24'h00_0000;
            holdoff_r  <= 24'h00_0000;
            timer_r    <= 24'h00_0000;
        end else if (wr_en) begin
            if (paddr == `WRTC_OFS_CTRL) begin
                ctrl_r <= pwdata[`WRTC_CTRL_W-1:0];
                if (pwdata[`WRTC_F_COMMON]) begin
                    ch1_mode_r <= pwdata[`WRTC_F_RUN +: 2];
                end
            end else if (paddr == `WRTC_OFS_CH1MODE) begin
                ch1_mode_r <= pwdata[1:0];
                if (ctrl_r[`WRTC_F_COMMON]) begin
                    ctrl_r[`WRTC_F_RUN +: 2] <= pwdata[1:0];
                end
            end else if (paddr == `WRTC_OFS_DELAY) begin
                delay_r <= clamp_delay(pwdata);
            end else if (paddr == `WRTC_OFS_COUNT) begin
                count_r <= clamp_count(pwdata);
            end else if (paddr == `WRTC_OFS_MINW) begin
                minw_r <= pwdata[23:0];
            end else if (paddr == `WRTC_OFS_MAXW) begin
                maxw_r <= pwdata[23:0];
            end else if (paddr == `WRTC_OFS_HOLDOFF) begin
                holdoff_r <= pwdata[23:0];
            end else if (paddr == `WRTC_OFS_TIMER) begin
                timer_r <= pwdata[23:0];
            end
        end
    end

    // Remote commands are one-cycle pulses from a CMD write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_trig_r  <= 1'b0;
            cmd_en_r    <= 1'b0;
            cmd_abort_r <= 1'b0;
        end else begin
            cmd_trig_r  <= wr_en & (paddr == `WRTC_OFS_CMD) & pwdata[`WRTC_CMD_TRIG];
            cmd_en_r    <= wr_en & (paddr == `WRTC_OFS_CMD) & pwdata[`WRTC_CMD_EN];
            cmd_abort_r <= wr_en & (paddr == `WRTC_OFS_CMD) & pwdata[`WRTC_CMD_ABORT];
        end
    end

    // ****************************************
    // Register reads
    // ****************************************
    logic        mapped;
    logic [31:0] rd_val;
    always_comb begin
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        if (paddr == `WRTC_OFS_CTRL) begin
            rd_val = {18'h0_0000, ctrl_r};
        end else if (paddr == `WRTC_OFS_CH1MODE) begin
            rd_val = {30'h0000_0000, ch1_mode_r};
        end else if (paddr == `WRTC_OFS_DELAY) begin
            rd_val = {9'h000, delay_r};
        end else if (paddr == `WRTC_OFS_COUNT) begin
            rd_val = {12'h000, count_r};
        end else if (paddr == `WRTC_OFS_MINW) begin
            rd_val = {8'h00, minw_r};
        end else if (paddr == `WRTC_OFS_MAXW) begin
            rd_val = {8'h00, maxw_r};
        end else if (paddr == `WRTC_OFS_HOLDOFF) begin
            rd_val = {8'h00, holdoff_r};
        end else if (paddr == `WRTC_OFS_TIMER) begin
            rd_val = {8'h00, timer_r};
        end else if (paddr == `WRTC_OFS_CMD) begin
            rd_val = 32'h0000_0000;
        end else if (paddr == `WRTC_OFS_STATUS) begin
            rd_val = {4'h0, burst_r, 3'h0, (hold_cnt_r != 24'h00_0000), state_r};
        end else begin
            mapped = 1'b0;
        end
    end

    // Read data and error are captured in the setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel & ~penable) begin
            prdata  <= rd_en ? rd_val : 32'h0000_0000;
            pslverr <= ~mapped;
        end
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
            prev_r  <= 3'h0;
        end else begin
            sync1_r <= {panel_push_stimulus, event_in, front_connector_source};
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    logic front_lvl;
    logic front_prv;
    logic hw_lvl;
    logic hw_prv;
    logic [1:0] hw_sel;
    assign front_lvl = sync2_r[0] | sync2_r[2];
    assign front_prv = prev_r[0] | prev_r[2];
    assign hw_lvl    = (trg_src == wrtc_pkg::TS_EVENT) ? sync2_r[1] : front_lvl;
    assign hw_prv    = (trg_src == wrtc_pkg::TS_EVENT) ? prev_r[1] : front_prv;
    assign hw_sel    = (trg_src == wrtc_pkg::TS_EVENT) ? evt_edge : trg_edge;

    // ****************************************
    // Pulse width qualifier
    // ****************************************
    logic act;
    logic act_prv;
    logic qual_on;
    logic qual_ok;
    logic pulse_end;
    assign act       = hw_lvl ^ (hw_sel == 2'b10);
    assign act_prv   = hw_prv ^ (hw_sel == 2'b10);
    assign pulse_end = act_prv & ~act;
    assign qual_on   = (minw_r != 24'h00_0000) | (maxw_r != 24'h00_0000);
    assign qual_ok   = ((minw_r == 24'h00_0000) | (width_r > minw_r)) &
                       ((maxw_r == 24'h00_0000) | (width_r < maxw_r));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            width_r <= 24'h00_0000;
        end else if (!act) begin
            width_r <= 24'h00_0000;
        end else if (width_r != 24'hFF_FFFF) begin
            width_r <= width_r + 24'h00_0001;
        end
    end

    // ****************************************
    // Trigger source selection
    // ****************************************
    logic hw_trig;
    logic timer_hit;
    logic raw_trig;
    logic auto_delay;
    assign hw_trig    = qual_on ? (pulse_end & qual_ok) : edge_hit(hw_lvl, hw_prv, hw_sel);
    assign timer_hit  = (timer_r != 24'h00_0000) && (tmr_cnt_r >= timer_r - 24'h00_0001);
    assign auto_delay = (trg_src == wrtc_pkg::TS_INT) && (delay_r != 23'h00_0000);

    always_comb begin
        case (trg_src)
            wrtc_pkg::TS_FRONT: raw_trig = hw_trig;
            wrtc_pkg::TS_BUS:   raw_trig = cmd_trig_r;
            wrtc_pkg::TS_INT:   raw_trig = timer_hit & ~auto_delay;
            default:            raw_trig = hw_trig;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr_cnt_r <= 24'h00_0000;
        end else if (trg_src != wrtc_pkg::TS_INT || run_mode != wrtc_pkg::RUN_TRIG || timer_hit) begin
            tmr_cnt_r <= 24'h00_0000;
        end else begin
            tmr_cnt_r <= tmr_cnt_r + 24'h00_0001;
        end
    end

    logic trig_ok;
    assign trig_ok = raw_trig && (hold_cnt_r == 24'h00_0000) &&
                     (override || state_r == wrtc_pkg::ST_IDLE) &&
                     (run_mode == wrtc_pkg::RUN_TRIG);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_cnt_r <= 24'h00_0000;
        end else if (trig_ok) begin
            hold_cnt_r <= holdoff_r;
        end else if (hold_cnt_r != 24'h00_0000) begin
            hold_cnt_r <= hold_cnt_r - 24'h00_0001;
        end
    end

    // ****************************************
    // Enable, abort and gate
    // ****************************************
    logic enable_ev;
    logic gate_open;
    logic run_ok;
    always_comb begin
        case (en_src)
            wrtc_pkg::EN_BUS:   enable_ev = cmd_en_r;
            wrtc_pkg::EN_EVENT: enable_ev = edge_hit(sync2_r[1], prev_r[1], evt_edge);
            wrtc_pkg::EN_FRONT: enable_ev = edge_hit(front_lvl, front_prv, trg_edge);
            default:            enable_ev = 1'b0;
        endcase
    end
    assign gate_open = hw_lvl ^ ctrl_r[`WRTC_F_GATEPOL];
    assign run_ok    = output_on & func_valid;

    // ****************************************
    // Run state machine
    // ****************************************
    logic start;
    logic load_delay;
    logic load_burst;
    logic dec_burst;
    logic use_delay;
    assign use_delay = delay_r != 23'h00_0000;

    always_comb begin
        state_nxt  = state_r;
        start      = 1'b0;
        load_delay = 1'b0;
        load_burst = 1'b0;
        dec_burst  = 1'b0;
        if (!run_ok) begin
            state_nxt = wrtc_pkg::ST_IDLE;
        end else if (run_mode == wrtc_pkg::RUN_CONT) begin
            if (!armed) begin
                start     = (state_r != wrtc_pkg::ST_PLAY) | wave_done;
                state_nxt = wrtc_pkg::ST_PLAY;
            end else if (cmd_abort_r) begin
                state_nxt = wrtc_pkg::ST_IDLE;
            end else if (state_r == wrtc_pkg::ST_PLAY) begin
                start = wave_done;
            end else if (enable_ev) begin
                start     = 1'b1;
                state_nxt = wrtc_pkg::ST_PLAY;
            end else begin
                state_nxt = wrtc_pkg::ST_IDLE;
            end
        end else if (run_mode == wrtc_pkg::RUN_TRIG) begin
            if (cmd_abort_r) begin
                state_nxt = wrtc_pkg::ST_IDLE;
            end else if (trig_ok || (state_r == wrtc_pkg::ST_IDLE && auto_delay)) begin
                load_burst = 1'b1;
                if (use_delay) begin
                    load_delay = 1'b1;
                    state_nxt  = wrtc_pkg::ST_DELAY;
                end else begin
                    start     = 1'b1;
                    state_nxt = wrtc_pkg::ST_PLAY;
                end
            end else begin
                case (state_r)
                    wrtc_pkg::ST_DELAY: begin
                        if (delay_cnt_r <= 23'h00_0001) begin
                            start     = 1'b1;
                            state_nxt = wrtc_pkg::ST_PLAY;
                        end
                    end
                    wrtc_pkg::ST_PLAY: begin
                        if (wave_done && burst_r > 20'h0_0001) begin
                            start     = 1'b1;
                            dec_burst = 1'b1;
                        end else if (wave_done && auto_delay) begin
                            load_burst = 1'b1;
                            load_delay = 1'b1;
                            state_nxt  = wrtc_pkg::ST_DELAY;
                        end else if (wave_done) begin
                            state_nxt = wrtc_pkg::ST_IDLE;
                        end
                    end
                    wrtc_pkg::ST_IDLE: state_nxt = wrtc_pkg::ST_IDLE;
                    default:           state_nxt = wrtc_pkg::ST_IDLE;
                endcase
            end
        end else begin
            if (cmd_abort_r) begin
                state_nxt = wrtc_pkg::ST_IDLE;
            end else if (state_r == wrtc_pkg::ST_PLAY) begin
                if (wave_done && gate_open) begin
                    start = 1'b1;
                end else if (wave_done) begin
                    state_nxt = wrtc_pkg::ST_IDLE;
                end
            end else if (gate_open) begin
                start     = 1'b1;
                state_nxt = wrtc_pkg::ST_PLAY;
            end else begin
                state_nxt = wrtc_pkg::ST_IDLE;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= wrtc_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            delay_cnt_r <= 23'h00_0000;
        end else if (load_delay) begin
            delay_cnt_r <= delay_r;
        end else if (delay_cnt_r != 23'h00_0000) begin
            delay_cnt_r <= delay_cnt_r - 23'h00_0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            burst_r <= 20'h0_0000;
        end else if (load_burst) begin
            burst_r <= count_r;
        end else if (dec_burst) begin
            burst_r <= burst_r - 20'h0_0001;
        end else if (state_nxt == wrtc_pkg::ST_IDLE) begin
            burst_r <= 20'h0_0000;
        end
    end

    // ****************************************
    // Engine outputs
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave_start  <= 1'b0;
            play_active <= 1'b0;
            hold_first  <= 1'b0;
            armed_idle  <= 1'b0;
        end else begin
            wave_start  <= start;
            play_active <= state_nxt == wrtc_pkg::ST_PLAY;
            hold_first  <= (state_nxt != wrtc_pkg::ST_PLAY) && (run_mode != wrtc_pkg::RUN_CONT);
            armed_idle  <= (state_nxt != wrtc_pkg::ST_PLAY) && (run_mode == wrtc_pkg::RUN_CONT) && armed;
        end
    end
endmodule
`default_nettype wire

// ---- inc/wrtc_defines.svh ----
`ifndef WRTC_DEFINES_SVH
`define WRTC_DEFINES_SVH
// ****************************************
// Register offsets
// ****************************************
`define WRTC_OFS_CTRL    8'h00
`define WRTC_OFS_CH1MODE 8'h04
`define WRTC_OFS_DELAY   8'h08
`define WRTC_OFS_COUNT   8'h0C
`define WRTC_OFS_MINW    8'h10
`define WRTC_OFS_MAXW    8'h14
`define WRTC_OFS_HOLDOFF 8'h18
`define WRTC_OFS_TIMER   8'h1C
`define WRTC_OFS_CMD     8'h20
`define WRTC_OFS_STATUS  8'h24
// ****************************************
// Control field positions
// ****************************************
`define WRTC_F_RUN       0
`define WRTC_F_ENMODE    2
`define WRTC_F_ENSRC     3
`define WRTC_F_TRGSRC    5
`define WRTC_F_RETRIG    7
`define WRTC_F_TRGEDGE   8
`define WRTC_F_EVTEDGE   10
`define WRTC_F_COMMON    12
`define WRTC_F_GATEPOL   13
`define WRTC_CTRL_W      14
`define WRTC_CMD_TRIG    0
`define WRTC_CMD_EN      1
`define WRTC_CMD_ABORT   2
// ****************************************
// Reset values and limits
// ****************************************
`define WRTC_RST_CTRL    14'h0500
`define WRTC_RST_COUNT   20'h0_0001
`define WRTC_MAX_COUNT   20'hF_4240
`define WRTC_MAX_DELAY   23'h7A_1200
`endif

// ---- inc/wrtc_pkg.sv ----
// ****************************************
// Shared types
// ****************************************
package wrtc_pkg;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_DELAY = 4'b0010,
        ST_PLAY  = 4'b0100,
        ST_SPARE = 4'b1000
    } wrtc_state_t;
    typedef enum logic [1:0] {
        RUN_CONT  = 2'b00,
        RUN_TRIG  = 2'b01,
        RUN_GATED = 2'b10
    } wrtc_run_t;
    typedef enum logic [1:0] {
        EN_BUS   = 2'b00,
        EN_EVENT = 2'b01,
        EN_FRONT = 2'b10
    } wrtc_ensrc_t;
    typedef enum logic [1:0] {
        TS_FRONT = 2'b00,
        TS_BUS   = 2'b01,
        TS_INT   = 2'b10,
        TS_EVENT = 2'b11
    } wrtc_trgsrc_t;
endpackage

// ---- verification/wrtc_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module wrtc_chk (
    // APB side
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // Playback side
    input wire logic        wave_start,
    input wire logic        play_active,
    input wire logic        hold_first,
    input wire logic        armed_idle,
    input wire logic [1:0]  ch1_run_mode
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_bad_setup;
        psel && !penable && paddr >= 8'h28;
    endsequence
    sequence s_good_setup;
        psel && !penable && paddr < 8'h28 && paddr[1:0] == 2'b00;
    endsequence
    sequence s_common_write;
        psel && penable && pwrite && paddr == 8'h00 && pwdata[12];
    endsequence
    a_start_play: assert property (wave_start |-> play_active) else $error("start outside play");
    a_start_pulse: assert property (wave_start |=> !wave_start) else $error("start longer than one cycle");
    a_hold_idle: assert property (hold_first |-> !play_active) else $error("hold while playing");
    a_armed_excl: assert property (armed_idle |-> !play_active) else $error("armed idle while playing");
    a_hold_armed: assert property (hold_first |-> !armed_idle) else $error("hold and armed idle together");
    a_bad_addr: assert property (s_bad_setup |=> pslverr && prdata == 32'h0000_0000) else $error("no error on unmapped");
    a_good_addr: assert property (s_good_setup |=> !pslverr) else $error("error on mapped address");
    a_mode_copy: assert property (s_common_write |=> ch1_run_mode == $past(pwdata[1:0])) else $error("mode not copied");
endmodule
`default_nettype wire

// ---- verification/wrtc_engine_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module wrtc_engine_model (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Playback handshake
    input  wire logic       wave_start,
    input  wire logic [4:0] wave_len,
    output logic            wave_done
);
    logic [4:0] left_r;
    // ****************************************
    // Cycle length counter
    // ****************************************
    // A new start restarts the cycle even when the last one is unfinished.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_r <= 5'h00;
            wave_done <= 1'b0;
        end else begin
            wave_done <= (left_r == 5'h01);
            if (wave_start) begin
                left_r <= wave_len;
            end else if (left_r != 5'h00) begin
                left_r <= left_r - 5'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, exp_v;
    logic        pready, pslverr, wave_start, play_active, hold_first, armed_idle, wave_done;
    logic        front_connector_source = 1'b0, event_in = 1'b0, panel_push_stimulus = 1'b0;
    logic        output_on = 1'b1, func_valid = 1'b1;
    logic [1:0]  ch1_run_mode;
    logic [4:0]  eng_len = 5'h04;
    logic [31:0] exp_q[$];
    int          errors = 0, comparisons = 0, n_start = 0;
    always #10 pclk = ~pclk;
    wrtc_top wrtc_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
        .front_connector_source, .event_in, .panel_push_stimulus, .output_on, .func_valid, .wave_done,
        .wave_start, .play_active, .hold_first, .armed_idle, .ch1_run_mode);
    wrtc_engine_model wrtc_engine_model_i (.pclk, .presetn, .wave_start, .wave_len(eng_len), .wave_done);
    task automatic end_sim();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) begin
            chk(pready, 1'b1);
            end_sim();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: return wave_start;
            1: return play_active;
            2: return hold_first;
            default: return armed_idle;
        endcase
    endfunction
    task automatic wait_lvl(input int s, input logic v);
        for (int k = 0; k < 80 && pick(s) !== v; k++) @(negedge pclk);
        chk(pick(s), v);
        if (pick(s) !== v) end_sim();
    endtask
    // Read results are matched against the oldest pending note.
    always @(posedge pclk) begin
        if (wave_start === 1'b1) n_start++;
        if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
            exp_v = exp_q.pop_front();
            chk(prdata, exp_v);
        end
    end
    initial begin
        int n;
        logic [31:0] r;
        r = $urandom(77551);
        eng_len <= 5'(2 + $urandom % 5);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        wait_lvl(0, 1'b1);
        rd(8'h00, 32'h0000_0500);
        $display("test reset done");
        apb(1'b1, 8'h00, 32'h0000_0121);
        wait_lvl(2, 1'b1);
        n = n_start;
        @(posedge pclk);
        front_connector_source <= 1'b1;
        repeat (6) @(posedge pclk);
        front_connector_source <= 1'b0;
        repeat (12) @(negedge pclk);
        chk(n_start, n);
        apb(1'b1, 8'h0C, 32'h0000_0003);
        apb(1'b1, 8'h20, 32'h0000_0001);
        wait_lvl(1, 1'b1);
        wait_lvl(2, 1'b1);
        chk(n_start, n + 3);
        apb(1'b1, 8'h0C, 32'h0000_0001);
        $display("test triggered done");
        eng_len <= 5'h14;
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, 8'h00, m ? 32'h0000_01A1 : 32'h0000_0121);
            n = n_start;
            apb(1'b1, 8'h20, 32'h0000_0001);
            wait_lvl(1, 1'b1);
            apb(1'b1, 8'h20, 32'h0000_0001);
            wait_lvl(2, 1'b1);
            chk(n_start, n + 1 + m);
        end
        apb(1'b1, 8'h20, 32'h0000_0001);
        wait_lvl(1, 1'b1);
        apb(1'b1, 8'h20, 32'h0000_0004);
        repeat (3) @(negedge pclk);
        chk(play_active, 1'b0);
        apb(1'b1, 8'h00, 32'h0000_0101);
        n = n_start;
        apb(1'b1, 8'h20, 32'h0000_0001);
        repeat (8) @(negedge pclk);
        chk(n_start, n);
        apb(1'b1, 8'h08, 32'h0000_000A);
        front_connector_source <= 1'b1;
        repeat (6) @(negedge pclk);
        chk(play_active, 1'b0);
        wait_lvl(0, 1'b1);
        @(posedge pclk);
        front_connector_source <= 1'b0;
        wait_lvl(2, 1'b1);
        $display("test retrigger done");
        apb(1'b1, 8'h00, 32'h0000_0104);
        wait_lvl(3, 1'b1);
        apb(1'b1, 8'h20, 32'h0000_0002);
        wait_lvl(1, 1'b1);
        apb(1'b1, 8'h20, 32'h0000_0004);
        wait_lvl(1, 1'b0);
        apb(1'b1, 8'h00, 32'h0000_0100);
        wait_lvl(1, 1'b1);
        apb(1'b1, 8'h20, 32'h0000_0004);
        repeat (6) @(negedge pclk);
        chk(play_active, 1'b1);
        $display("test armed done");
        apb(1'b1, 8'h00, 32'h0000_1102);
        rd(8'h04, 32'h0000_0002);
        r = $urandom & 32'h003F_FFFF;
        apb(1'b1, 8'h08, r);
        rd(8'h08, r);
        rd(8'h28, 32'h0000_0000);
        repeat (2) @(posedge pclk);
        $display("test registers done");
        end_sim();
    end
endmodule
bind wrtc_top wrtc_chk wrtc_chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr,
    .wave_start, .play_active, .hold_first, .armed_idle, .ch1_run_mode);
`default_nettype wire
